// ===== mcr_misc_config.sv
`timescale 1ns/1ps
`default_nettype none

module mcr_misc_config
  import mcr_pkg::*;
#(
  parameter int unsigned CLKRUN_HOLD = MCR_CLKRUN_HOLD_DEF
)
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic cfg_sel,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_addr,
  input wire logic [3:0] cfg_byte_en,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_done,
  output logic cfg_claim,
  output logic [31:0] cfg_rdata,
  output logic wake_from_cold_off_cap,
  output logic wake_from_light_sleep_cap,
  output logic light_sleep_state_cap,
  input wire logic link_req,
  input wire logic link_sclk_active,
  output logic link_abort,
  output logic link_fill,
  output logic link_pass,
  output logic [31:0] link_fill_data,
  input wire logic general_pin_three_in,
  input wire logic general_pin_two_in,
  input wire logic gpio_three_out,
  input wire logic gpio_three_oe,
  input wire logic gpio_two_out,
  input wire logic gpio_two_oe,
  input wire logic tw_clk_pull_low,
  input wire logic tw_data_pull_low,
  output logic general_pin_three_out,
  output logic general_pin_three_oe,
  output logic general_pin_two_out,
  output logic general_pin_two_oe,
  output logic gpio_three_in,
  output logic gpio_two_in,
  output logic tw_clk_in,
  output logic tw_data_in,
  input wire logic link_gate_req,
  input wire logic host_gate_req,
  output logic link_clock_gate_bypass,
  output logic host_clock_gate_bypass,
  output logic link_clock_enable,
  output logic host_clock_enable,
  input wire logic clkrun_n_in,
  input wire logic host_clock_needed,
  output logic clkrun_n_out,
  output logic clkrun_n_oe,
  output logic host_clock_stop_ok
);

  typedef struct packed {
    mcr_fields_t f;
    logic done;
    logic claim;
    logic [31:0] rdata;
    logic abort;
    logic fill;
    logic pass;
    logic [31:0] fill_data;
    logic link_en;
    logic host_en;
  } mcr_state_t;

  mcr_state_t st_reg;
  mcr_state_t st_next;

  mcr_clkrun_if ck_if ();

  // bits the field positions claim; must match the storage mask
  function automatic logic [31:0] field_bits();
    logic [31:0] v;
    v = '0;
    v[MCR_BIT_COLD_WAKE] = 1'b1;
    v[MCR_BIT_D2_WAKE] = 1'b1;
    v[MCR_BIT_D2_CAP] = 1'b1;
    v[MCR_BIT_SUPPRESS] = 1'b1;
    v[MCR_BIT_ROUTE] = 1'b1;
    v[MCR_BIT_LINK_BYP] = 1'b1;
    v[MCR_BIT_HOST_BYP] = 1'b1;
    v[MCR_BIT_KEEP] = 1'b1;
    return v;
  endfunction

  initial
  begin
    if (CLKRUN_HOLD < 1 || CLKRUN_HOLD > 255)
    begin
      $error("clkrun hold out of range");
    end
    // a field moved onto a reserved bit would break the read-zero rules
    if (field_bits() != MCR_WRITE_MASK || (MCR_RESET & ~MCR_WRITE_MASK) != 32'h0)
    begin
      $error("field map disagrees with storage mask");
    end
  end

  function automatic mcr_fields_t unpack_fields(input logic [31:0] v);
    mcr_fields_t r;
    r.cold_wake = v[MCR_BIT_COLD_WAKE];
    r.d2_wake = v[MCR_BIT_D2_WAKE];
    r.d2_cap = v[MCR_BIT_D2_CAP];
    r.suppress = v[MCR_BIT_SUPPRESS];
    r.route = v[MCR_BIT_ROUTE];
    r.link_byp = v[MCR_BIT_LINK_BYP];
    r.host_byp = v[MCR_BIT_HOST_BYP];
    r.keep = v[MCR_BIT_KEEP];
    return r;
  endfunction

  function automatic logic [31:0] pack_fields(input mcr_fields_t f);
    logic [31:0] v;
    v = '0;
    v[MCR_BIT_COLD_WAKE] = f.cold_wake;
    v[MCR_BIT_D2_WAKE] = f.d2_wake;
    v[MCR_BIT_D2_CAP] = f.d2_cap;
    v[MCR_BIT_SUPPRESS] = f.suppress;
    v[MCR_BIT_ROUTE] = f.route;
    v[MCR_BIT_LINK_BYP] = f.link_byp;
    v[MCR_BIT_HOST_BYP] = f.host_byp;
    v[MCR_BIT_KEEP] = f.keep;
    return v & MCR_WRITE_MASK;
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // dword decode of this register, shared by read and write paths
  function automatic logic addr_hit(input logic sel, input logic [7:0] a);
    return sel && (a[7:2] == MCR_OFFSET[7:2]);
  endfunction

  logic hit;
  logic [31:0] cur_word;
  logic [31:0] lanes;
  logic [31:0] merged;

  always_comb
  begin
    st_next = st_reg;
    hit = addr_hit(cfg_sel, cfg_addr);
    cur_word = pack_fields(st_reg.f);
    // disabled lanes keep their old contents, so partial writes are safe
    lanes = lane_mask(cfg_byte_en);
    merged = (cur_word & ~lanes) | (cfg_wdata & lanes);

    // config cycle answer, one cycle after the request
    st_next.done = cfg_sel;
    st_next.claim = hit;
    st_next.rdata = '0;
    if (hit && !cfg_write)
    begin
      st_next.rdata = cur_word;
    end
    if (hit && cfg_write)
    begin
      st_next.f = unpack_fields(merged);
    end

    // stopped-link access handling; a live clock passes the access on
    // fill data stays zero outside link_fill so all ones never leaks onto a pass
    st_next.abort = 1'b0;
    st_next.fill = 1'b0;
    st_next.pass = 1'b0;
    st_next.fill_data = '0;
    if (link_req)
    begin
      if (link_sclk_active)
      begin
        st_next.pass = 1'b1;
      end
      else if (!st_reg.f.suppress)
      begin
        st_next.abort = 1'b1;
      end
      else
      begin
        st_next.fill = 1'b1;
        st_next.fill_data = {4{MCR_FILL_BYTE}};
      end
    end

    // registered so a bypass change cannot glitch the gate enable
    // link and host gate bypass
    st_next.link_en = st_reg.f.link_byp || link_gate_req;
    st_next.host_en = st_reg.f.host_byp || host_gate_req;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      st_reg <= '0;
      st_reg.f <= unpack_fields(MCR_RESET);
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign cfg_done = st_reg.done;
  assign cfg_claim = st_reg.claim;
  assign cfg_rdata = st_reg.rdata;

  assign wake_from_cold_off_cap = st_reg.f.cold_wake;
  assign wake_from_light_sleep_cap = st_reg.f.d2_wake;
  assign light_sleep_state_cap = st_reg.f.d2_cap;

  assign link_abort = st_reg.abort;
  assign link_fill = st_reg.fill;
  assign link_pass = st_reg.pass;
  assign link_fill_data = st_reg.fill_data;

  // pin routing
  // when routed the general-purpose drivers are off; the two-wire engine
  // only pulls low, so the pins otherwise float at the external pull-up
  always_comb
  begin
    if (st_reg.f.route)
    begin
      general_pin_three_out = 1'b0;
      general_pin_three_oe = tw_clk_pull_low;
      general_pin_two_out = 1'b0;
      general_pin_two_oe = tw_data_pull_low;
      gpio_three_in = 1'b0;
      gpio_two_in = 1'b0;
      tw_clk_in = general_pin_three_in;
      tw_data_in = general_pin_two_in;
    end
    else
    begin
      general_pin_three_out = gpio_three_out;
      general_pin_three_oe = gpio_three_oe;
      general_pin_two_out = gpio_two_out;
      general_pin_two_oe = gpio_two_oe;
      gpio_three_in = general_pin_three_in;
      gpio_two_in = general_pin_two_in;
      // idle high so the engine sees a released bus
      tw_clk_in = 1'b1;
      tw_data_in = 1'b1;
    end
  end

  assign link_clock_gate_bypass = st_reg.f.link_byp;
  assign host_clock_gate_bypass = st_reg.f.host_byp;
  assign link_clock_enable = st_reg.link_en;
  assign host_clock_enable = st_reg.host_en;

  assign ck_if.keep_running = st_reg.f.keep;
  assign ck_if.clock_needed = host_clock_needed;
  assign ck_if.clkrun_n_in = clkrun_n_in;
  assign clkrun_n_out = ck_if.clkrun_n_out;
  assign clkrun_n_oe = ck_if.clkrun_n_oe;
  assign host_clock_stop_ok = ck_if.stop_allowed;

  mcr_clkrun_keeper #(
    .HOLD(CLKRUN_HOLD)
  ) u_keeper (
    .mclk(mclk),
    .srst(srst),
    .ck(ck_if.keeper)
  );

endmodule

`default_nettype wire

// ===== mcr_pkg.sv
package mcr_pkg;

  // configuration space placement
  localparam logic [7:0] MCR_OFFSET = 8'hf0;
  localparam logic [31:0] MCR_RESET = 32'h0000_2400;

  // field positions
  localparam int unsigned MCR_BIT_COLD_WAKE = 15;
  localparam int unsigned MCR_BIT_D2_WAKE = 13;
  localparam int unsigned MCR_BIT_D2_CAP = 10;
  localparam int unsigned MCR_BIT_SUPPRESS = 4;
  localparam int unsigned MCR_BIT_ROUTE = 3;
  localparam int unsigned MCR_BIT_LINK_BYP = 2;
  localparam int unsigned MCR_BIT_HOST_BYP = 1;
  localparam int unsigned MCR_BIT_KEEP = 0;

  // bits that hold storage; everything else reads zero
  localparam logic [31:0] MCR_WRITE_MASK = 32'h0000_a41f;

  // data handed back for an access to a stopped link domain
  localparam logic [7:0] MCR_FILL_BYTE = 8'hff;

  // cycles the clock-request line is pulled low before release
  localparam int unsigned MCR_CLKRUN_HOLD_DEF = 2;

  typedef struct packed {
    logic cold_wake;
    logic d2_wake;
    logic d2_cap;
    logic suppress;
    logic route;
    logic link_byp;
    logic host_byp;
    logic keep;
  } mcr_fields_t;

  typedef enum logic [2:0] {
    MCR_CK_WATCH = 3'b001,
    MCR_CK_DRIVE = 3'b010,
    MCR_CK_RELEASE = 3'b100
  } mcr_ck_state_t;

endpackage

// ===== mcr_clkrun_if.sv
`timescale 1ns/1ps
`default_nettype none

interface mcr_clkrun_if;
  logic keep_running;
  logic clock_needed;
  logic clkrun_n_in;
  logic clkrun_n_out;
  logic clkrun_n_oe;
  logic stop_allowed;

  modport ctrl (
    output keep_running,
    output clock_needed,
    output clkrun_n_in,
    input clkrun_n_out,
    input clkrun_n_oe,
    input stop_allowed
  );

  modport keeper (
    input keep_running,
    input clock_needed,
    input clkrun_n_in,
    output clkrun_n_out,
    output clkrun_n_oe,
    output stop_allowed
  );
endinterface

`default_nettype wire

// ===== mcr_clkrun_keeper.sv
`timescale 1ns/1ps
`default_nettype none

module mcr_clkrun_keeper
  import mcr_pkg::*;
#(
  parameter int unsigned HOLD = MCR_CLKRUN_HOLD_DEF
)
(
  input wire logic mclk,
  input wire logic srst,
  mcr_clkrun_if.keeper ck
);

  localparam int unsigned CW = $clog2(HOLD + 1);

  typedef struct packed {
    mcr_ck_state_t state;
    logic [CW-1:0] count;
  } mcr_keeper_t;

  mcr_keeper_t st_reg;
  mcr_keeper_t st_next;

  initial
  begin
    if (HOLD < 1 || HOLD > 255)
    begin
      $error("hold count out of range");
    end
  end

  always_comb
  begin
    st_next = st_reg;
    unique case (st_reg.state)
      MCR_CK_WATCH:
      begin
        // host released the line to ask for a stop; refuse if we need the clock
        if (ck.clkrun_n_in && (ck.keep_running || ck.clock_needed))
        begin
          st_next.state = MCR_CK_DRIVE;
          st_next.count = CW'(HOLD - 1);
        end
      end
      MCR_CK_DRIVE:
      begin
        if (st_reg.count == '0)
        begin
          st_next.state = MCR_CK_RELEASE;
        end
        else
        begin
          st_next.count = st_reg.count - 1'b1;
        end
      end
      MCR_CK_RELEASE:
      begin
        st_next.state = MCR_CK_WATCH;
      end
      default:
      begin
        st_next.state = MCR_CK_WATCH;
        st_next.count = '0;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      st_reg <= '{state: MCR_CK_WATCH, count: '0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // drive low while holding, drive high one cycle so the line is not left low
  assign ck.clkrun_n_out = (st_reg.state == MCR_CK_RELEASE);
  assign ck.clkrun_n_oe = (st_reg.state != MCR_CK_WATCH);
  assign ck.stop_allowed = !(ck.keep_running || ck.clock_needed)
                           && (st_reg.state == MCR_CK_WATCH);

endmodule

`default_nettype wire

// ===== mcr_misc_config_checker.sv
`timescale 1ns/1ps
`default_nettype none
module mcr_misc_config_checker
  import mcr_pkg::*;
#(
  parameter int unsigned CLKRUN_HOLD = MCR_CLKRUN_HOLD_DEF
)
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic cfg_sel,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_addr,
  input wire logic cfg_claim,
  input wire logic [31:0] cfg_rdata,
  input wire logic link_req,
  input wire logic link_sclk_active,
  input wire logic link_abort,
  input wire logic link_fill,
  input wire logic [31:0] link_fill_data,
  input wire logic general_pin_three_in,
  input wire logic gpio_three_in,
  input wire logic tw_clk_in,
  input wire logic link_clock_gate_bypass,
  input wire logic host_clock_gate_bypass,
  input wire logic link_clock_enable,
  input wire logic host_clock_enable,
  input wire logic clkrun_n_out,
  input wire logic clkrun_n_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  property p_claim;
    cfg_sel && !cfg_write && cfg_addr[7:2] == 6'h3c |=> cfg_claim;
  endproperty
  a_claim: assert property (p_claim) else $error("claim");
  property p_rsvd;
    (cfg_rdata & ~MCR_WRITE_MASK) == 32'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("rsvd");
  property p_abort;
    link_req && !link_sclk_active |=> link_abort != link_fill;
  endproperty
  a_abort: assert property (p_abort) else $error("abort");
  property p_fill;
    link_fill |-> link_fill_data == 32'hffff_ffff;
  endproperty
  a_fill: assert property (p_fill) else $error("fill");
  property p_route;
    !tw_clk_in |-> !general_pin_three_in && !gpio_three_in;
  endproperty
  a_route: assert property (p_route) else $error("route");
  property p_link_en;
    link_clock_gate_bypass |=> link_clock_enable;
  endproperty
  a_link_en: assert property (p_link_en) else $error("link en");
  property p_host_en;
    host_clock_gate_bypass |=> host_clock_enable;
  endproperty
  a_host_en: assert property (p_host_en) else $error("host en");
  property p_keep;
    $rose(clkrun_n_oe) |-> !clkrun_n_out [*2] ##1 clkrun_n_out ##1 !clkrun_n_oe;
  endproperty
  a_keep: assert property (p_keep) else $error("keep");
endmodule
bind mcr_misc_config mcr_misc_config_checker #(.CLKRUN_HOLD(CLKRUN_HOLD)) i_chk (
  .mclk(mclk), .srst(srst), .cfg_sel(cfg_sel), .cfg_write(cfg_write),
  .cfg_addr(cfg_addr), .cfg_claim(cfg_claim), .cfg_rdata(cfg_rdata),
  .link_req(link_req), .link_sclk_active(link_sclk_active),
  .link_abort(link_abort), .link_fill(link_fill), .link_fill_data(link_fill_data),
  .general_pin_three_in(general_pin_three_in), .gpio_three_in(gpio_three_in),
  .tw_clk_in(tw_clk_in), .link_clock_gate_bypass(link_clock_gate_bypass),
  .host_clock_gate_bypass(host_clock_gate_bypass),
  .link_clock_enable(link_clock_enable), .host_clock_enable(host_clock_enable),
  .clkrun_n_out(clkrun_n_out), .clkrun_n_oe(clkrun_n_oe)
);
`default_nettype wire

// ===== mcr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module mcr_host_model
(
  input wire logic mclk,
  output logic cfg_sel,
  output logic cfg_write,
  output logic [7:0] cfg_addr,
  output logic [3:0] cfg_byte_en,
  output logic [31:0] cfg_wdata,
  input wire logic cfg_done,
  input wire logic cfg_claim,
  input wire logic [31:0] cfg_rdata
);
  logic [33:0] got;
  initial
  begin
    cfg_sel = 1'b0;
    cfg_write = 1'b0;
    cfg_addr = 8'h00;
    cfg_byte_en = 4'h0;
    cfg_wdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] b,
    input logic [31:0] d);
    @(negedge mclk);
    cfg_sel = 1'b1;
    cfg_write = w;
    cfg_addr = a;
    cfg_byte_en = b;
    cfg_wdata = d;
    @(negedge mclk);
    // the answer stands only until the next rising edge
    got = {cfg_done, cfg_claim, cfg_rdata};
    cfg_sel = 1'b0;
    // released address and write data lines invert, so a stale value never passes
    cfg_addr = ~a;
    cfg_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// ===== mcr_misc_config_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mcr_misc_config_tb_top
  import mcr_pkg::*;
;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic cfg_sel, cfg_write, cfg_done, cfg_claim;
  logic [7:0] cfg_addr;
  logic [3:0] cfg_byte_en;
  logic [31:0] cfg_wdata, cfg_rdata, link_fill_data, e;
  logic wake_from_cold_off_cap, wake_from_light_sleep_cap, light_sleep_state_cap;
  logic link_req = 1'b0, link_sclk_active = 1'b0, link_abort, link_fill, link_pass;
  logic general_pin_three_in, general_pin_two_in, gpio_three_in, gpio_two_in;
  logic gpio_three_out = 1'b1, gpio_three_oe = 1'b1, tw_clk_pull_low = 1'b0, p3_ext = 1'b1;
  logic gpio_two_out = 1'b0, gpio_two_oe = 1'b0, tw_data_pull_low = 1'b0;
  logic general_pin_three_out, general_pin_three_oe, general_pin_two_out, general_pin_two_oe;
  logic tw_clk_in, tw_data_in, link_gate_req = 1'b0, host_gate_req = 1'b0;
  logic link_clock_gate_bypass, host_clock_gate_bypass, link_clock_enable, host_clock_enable;
  logic clkrun_n_in, host_clock_needed = 1'b0, clkrun_n_out, clkrun_n_oe, host_clock_stop_ok;
  int n_fail = 0;
  int checks_done = 0;
  logic [67:0] rows [5] = '{
    {4'hf, 32'hffff_ffff, 32'h0000_a41f},
    {4'h1, 32'h0000_0000, 32'h0000_a400},
    {4'h2, 32'h0000_0000, 32'h0000_0000},
    {4'hc, 32'hffff_ffff, 32'h0000_0000},
    {4'h3, 32'h0000_8411, 32'h0000_8411}
  };
  // pulled-up shared lines
  assign general_pin_three_in = general_pin_three_oe ? general_pin_three_out : p3_ext;
  assign general_pin_two_in = general_pin_two_oe ? general_pin_two_out : 1'b1;
  assign clkrun_n_in = clkrun_n_oe ? clkrun_n_out : 1'b1;
  always #50 mclk = ~mclk;
  mcr_misc_config #(.CLKRUN_HOLD(2)) i_dut (
    .mclk(mclk), .srst(srst), .cfg_sel(cfg_sel), .cfg_write(cfg_write),
    .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
    .cfg_done(cfg_done), .cfg_claim(cfg_claim), .cfg_rdata(cfg_rdata),
    .wake_from_cold_off_cap(wake_from_cold_off_cap),
    .wake_from_light_sleep_cap(wake_from_light_sleep_cap),
    .light_sleep_state_cap(light_sleep_state_cap),
    .link_req(link_req), .link_sclk_active(link_sclk_active), .link_abort(link_abort),
    .link_fill(link_fill), .link_pass(link_pass), .link_fill_data(link_fill_data),
    .general_pin_three_in(general_pin_three_in), .general_pin_two_in(general_pin_two_in),
    .gpio_three_out(gpio_three_out), .gpio_three_oe(gpio_three_oe),
    .gpio_two_out(gpio_two_out), .gpio_two_oe(gpio_two_oe),
    .tw_clk_pull_low(tw_clk_pull_low), .tw_data_pull_low(tw_data_pull_low),
    .general_pin_three_out(general_pin_three_out),
    .general_pin_three_oe(general_pin_three_oe),
    .general_pin_two_out(general_pin_two_out), .general_pin_two_oe(general_pin_two_oe),
    .gpio_three_in(gpio_three_in), .gpio_two_in(gpio_two_in),
    .tw_clk_in(tw_clk_in), .tw_data_in(tw_data_in),
    .link_gate_req(link_gate_req), .host_gate_req(host_gate_req),
    .link_clock_gate_bypass(link_clock_gate_bypass),
    .host_clock_gate_bypass(host_clock_gate_bypass),
    .link_clock_enable(link_clock_enable), .host_clock_enable(host_clock_enable),
    .clkrun_n_in(clkrun_n_in), .host_clock_needed(host_clock_needed),
    .clkrun_n_out(clkrun_n_out), .clkrun_n_oe(clkrun_n_oe),
    .host_clock_stop_ok(host_clock_stop_ok)
  );
  mcr_host_model i_host (
    .mclk(mclk), .cfg_sel(cfg_sel), .cfg_write(cfg_write), .cfg_addr(cfg_addr),
    .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata), .cfg_done(cfg_done),
    .cfg_claim(cfg_claim), .cfg_rdata(cfg_rdata)
  );
  task automatic chk(input string n, input logic [35:0] x, input logic [35:0] g);
    checks_done++;
    if (g !== x)
    begin
      n_fail++;
      $display("ERROR %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] x);
    i_host.xfer(1'b0, a, 4'hf, 32'h0);
    chk("cfg", x, i_host.got);
  endtask
  task automatic lk(input logic a, input logic [34:0] x);
    @(negedge mclk);
    link_req = 1'b1;
    link_sclk_active = a;
    @(negedge mclk);
    // the answer stands only until the next rising edge
    chk("link", x, {link_abort, link_fill, link_pass, link_fill_data});
    link_req = 1'b0;
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #(100 * 3000);
    n_fail++;
    report_and_stop();
  end
  initial
  begin
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    srst = 1'b0;
    rd(8'hf0, {2'b11, MCR_RESET});
    lk(1'b0, {3'b100, 32'h0});
    chk("route", 4'b1111, {tw_clk_in, gpio_three_in, general_pin_three_oe,
      general_pin_three_out});
    foreach (rows[i])
    begin
      i_host.xfer(1'b1, 8'hf0, rows[i][67:64], rows[i][63:32]);
      e = rows[i][31:0];
      rd(8'hf0, {2'b11, e});
      chk("caps", {e[15], e[13], e[10], e[2], e[1], e[2], e[1]},
        {wake_from_cold_off_cap, wake_from_light_sleep_cap, light_sleep_state_cap,
        link_clock_gate_bypass, host_clock_gate_bypass, link_clock_enable, host_clock_enable});
    end
    lk(1'b0, {3'b010, 32'hffff_ffff});
    lk(1'b1, {3'b001, 32'h0});
    i_host.xfer(1'b1, 8'hf4, 4'hf, 32'hffff_ffff);
    rd(8'hf4, {2'b10, 32'h0});
    rd(8'hf0, {2'b11, 32'h0000_8411});
    i_host.xfer(1'b1, 8'hf0, 4'h1, 32'h0000_0008);
    // keeper may be mid-hold; let it return to idle
    repeat (4) @(negedge mclk);
    chk("stop ok", 1'b1, host_clock_stop_ok);
    @(negedge mclk);
    tw_clk_pull_low = 1'b1;
    #1;
    chk("route", 7'b0010100, {tw_clk_in, gpio_three_in, general_pin_three_oe,
      general_pin_three_out, tw_data_in, gpio_two_in, general_pin_two_oe});
    @(negedge mclk);
    tw_clk_pull_low = 1'b0;
    host_clock_needed = 1'b1;
    #1;
    chk("route", 4'b1000, {tw_clk_in, gpio_three_in, general_pin_three_oe,
      general_pin_three_out});
    repeat (6) @(negedge mclk);
    chk("stop ok", 1'b0, host_clock_stop_ok);
    srst = 1'b1;
    repeat (2) @(negedge mclk);
    srst = 1'b0;
    rd(8'hf0, {2'b11, MCR_RESET});
    report_and_stop();
  end
endmodule
`default_nettype wire
